/* File: rtl/ssp_pin_port.sv */
// Four shared pins: general-purpose port or synchronous serial port channel
`timescale 1ns/1ps
module ssp_pin_port
  import ssp_pkg::*;
#(
  parameter int unsigned WORD_LEN = WORD_LEN_DEF,
  parameter int unsigned CLK_DIV  = CLK_DIV_DEF
) (
  // System clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  // Link clock (bit clock as seen at its pin)
  input  wire logic                    i_link_clk,
  // Register port
  input  wire ssp_pkg::ssp_bus_req_t   i_bus,
  output logic      [DATA_W-1:0]       o_rdata,
  // Pins
  input  wire logic [NUM_PINS-1:0]     i_pin,
  output ssp_pkg::ssp_pin_drive_t      o_pin
);

  import ssp_pkg::*;

  localparam int unsigned CNT_W = $clog2(WORD_LEN + 1);
  localparam int unsigned DIV_W = $clog2(CLK_DIV + 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_LEN - 1);
  localparam logic [DIV_W-1:0] LAST_DIV = DIV_W'(CLK_DIV - 1);

  function automatic logic [DATA_W-1:0] widen4(input logic [3:0] v);
    widen4 = {{(DATA_W-4){1'b0}}, v};
  endfunction : widen4

  // ==========================================================================
  // Registers
  logic [3:0]          ctrl_reg;
  logic [3:0]          dir_reg;
  logic [3:0]          gpout_reg;
  logic [3:0]          mode_reg;
  logic [WORD_LEN-1:0] tx_hold_reg;
  logic [WORD_LEN-1:0] rx_data_reg;
  logic                tx_full_reg;
  logic                rx_full_reg;
  logic                rx_ovr_reg;
  logic                tx_und_reg;

  logic [NUM_PINS-1:0] pin_s;
  logic                sync_mode;
  logic                fs_out;
  logic                ck_out;
  logic                tx_en;
  logic                wr_tx;
  logic                rd_rx;

  assign sync_mode = mode_reg[MODE_SYNC];
  assign fs_out    = mode_reg[MODE_FS_OUT];
  assign ck_out    = mode_reg[MODE_CK_OUT];
  assign tx_en     = mode_reg[MODE_TX_EN] & ctrl_reg[PIN_TX];
  assign wr_tx     = i_bus.wr && (i_bus.addr == ADDR_TXDATA);
  assign rd_rx     = i_bus.rd && (i_bus.addr == ADDR_RXDATA);

  // ==========================================================================
  // Pin input synchronisers
  ssp_sync2 #(.W(NUM_PINS)) u_pin_sync (
    .i_clk (i_clk),
    .i_d   (i_pin),
    .o_q   (pin_s)
  );

  // ==========================================================================
  // Control registers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_reg  <= CTRL_RESET;
      dir_reg   <= DIR_RESET;
      gpout_reg <= GPOUT_RESET;
      mode_reg  <= MODE_RESET;
    end else if (i_bus.wr) begin
      unique case (i_bus.addr)
        ADDR_CTRL:  ctrl_reg  <= i_bus.wdata[3:0];
        ADDR_DIR:   dir_reg   <= i_bus.wdata[3:0];
        ADDR_GPOUT: gpout_reg <= i_bus.wdata[3:0];
        ADDR_MODE:  mode_reg  <= i_bus.wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (wr_tx) begin
      tx_hold_reg <= i_bus.wdata[WORD_LEN-1:0];
    end
  end

  // ==========================================================================
  // Bit clock generation and edge detection
  logic [DIV_W-1:0] div_reg;
  logic             ck_gen_reg;
  logic             ck_ext_prev_reg;
  logic             bit_rise;

  always_ff @(posedge i_clk) begin
    if (i_reset || !ck_out) begin
      div_reg    <= '0;
      ck_gen_reg <= 1'b0;
    end else if (div_reg == LAST_DIV) begin
      div_reg    <= '0;
      ck_gen_reg <= ~ck_gen_reg;
    end else begin
      div_reg    <= div_reg + DIV_W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ck_ext_prev_reg <= 1'b0;
    end else begin
      ck_ext_prev_reg <= pin_s[PIN_CLK];
    end
  end

  always_comb begin
    if (!ctrl_reg[PIN_CLK]) begin
      bit_rise = 1'b0;
    end else if (ck_out) begin
      bit_rise = (div_reg == LAST_DIV) && !ck_gen_reg;
    end else begin
      bit_rise = pin_s[PIN_CLK] && !ck_ext_prev_reg;
    end
  end

  // ==========================================================================
  // Frame sync generation
  logic [CNT_W-1:0] fs_cnt_reg;
  logic             fs_gen_reg;
  logic             fs_level;
  logic             frame_start;

  always_ff @(posedge i_clk) begin
    if (i_reset || !fs_out) begin
      fs_cnt_reg <= '0;
      fs_gen_reg <= 1'b0;
    end else if (bit_rise) begin
      fs_gen_reg <= (fs_cnt_reg == '0);
      fs_cnt_reg <= (fs_cnt_reg == LAST_BIT) ? '0 : fs_cnt_reg + CNT_W'(1);
    end
  end

  assign fs_level    = fs_out ? fs_gen_reg : pin_s[PIN_FS];
  assign frame_start = bit_rise && ctrl_reg[PIN_FS] && fs_level;

  // ==========================================================================
  // Transmitter
  logic [WORD_LEN-1:0] tx_shift_reg;
  logic [CNT_W-1:0]    tx_cnt_reg;
  logic                tx_active_reg;
  logic                tx_load;

  assign tx_load = frame_start && tx_en && !tx_active_reg && tx_full_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset || !tx_en) begin
      tx_active_reg <= 1'b0;
      tx_cnt_reg    <= '0;
    end else if (tx_load) begin
      tx_shift_reg  <= tx_hold_reg;
      tx_cnt_reg    <= '0;
      tx_active_reg <= 1'b1;
    end else if (bit_rise && tx_active_reg) begin
      if (tx_cnt_reg == LAST_BIT) begin
        tx_active_reg <= 1'b0;
      end else begin
        tx_shift_reg <= {tx_shift_reg[WORD_LEN-2:0], 1'b0};
        tx_cnt_reg   <= tx_cnt_reg + CNT_W'(1);
      end
    end
  end

  // Holding register flags; a new event wins over a clear
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_full_reg <= 1'b0;
    end else if (wr_tx) begin
      tx_full_reg <= 1'b1;
    end else if (tx_load) begin
      tx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      tx_und_reg <= 1'b0;
    end else if (frame_start && tx_en && !tx_active_reg && !tx_full_reg) begin
      tx_und_reg <= 1'b1;
    end else if (i_bus.wr && i_bus.addr == ADDR_STATUS && i_bus.wdata[ST_TX_UND]) begin
      tx_und_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Receiver in the link domain and word crossing
  logic [WORD_LEN-1:0] link_word;
  logic                link_toggle;
  logic                toggle_s;
  logic                toggle_prev_reg;
  logic                rx_done;
  logic                rx_enable_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_enable_reg <= 1'b0;
    end else begin
      rx_enable_reg <= sync_mode && (&ctrl_reg[PIN_RX:PIN_FS]);
    end
  end

  ssp_link_rx #(.WORD_LEN(WORD_LEN)) u_link_rx (
    .i_link_clk   (i_link_clk),
    .i_enable     (rx_enable_reg),
    .i_frame_sync (i_pin[PIN_FS]),
    .i_rx_data    (i_pin[PIN_RX]),
    .o_word       (link_word),
    .o_toggle     (link_toggle)
  );

  ssp_sync2 #(.W(1)) u_tog_sync (
    .i_clk (i_clk),
    .i_d   (link_toggle),
    .o_q   (toggle_s)
  );

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      toggle_prev_reg <= 1'b0;
    end else begin
      toggle_prev_reg <= toggle_s;
    end
  end

  assign rx_done = (toggle_s != toggle_prev_reg) && rx_enable_reg;

  always_ff @(posedge i_clk) begin
    if (rx_done) begin
      rx_data_reg <= link_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_full_reg <= 1'b0;
    end else if (rx_done) begin
      rx_full_reg <= 1'b1;
    end else if (rd_rx) begin
      rx_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rx_ovr_reg <= 1'b0;
    end else if (rx_done && rx_full_reg && !rd_rx) begin
      rx_ovr_reg <= 1'b1;
    end else if (i_bus.wr && i_bus.addr == ADDR_STATUS && i_bus.wdata[ST_RX_OVR]) begin
      rx_ovr_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // Pin drive
  ssp_pin_drive_t drive_next;

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      drive_next.out[i]  = gpout_reg[i];
      drive_next.oe_n[i] = ~dir_reg[i];
    end
    if (ctrl_reg[PIN_FS]) begin
      drive_next.out[PIN_FS]  = fs_gen_reg;
      drive_next.oe_n[PIN_FS] = ~fs_out;
    end
    if (ctrl_reg[PIN_CLK]) begin
      drive_next.out[PIN_CLK]  = ck_gen_reg;
      drive_next.oe_n[PIN_CLK] = ~ck_out;
    end
    if (ctrl_reg[PIN_RX]) begin
      drive_next.out[PIN_RX]  = 1'b0;
      drive_next.oe_n[PIN_RX] = 1'b1;
    end
    if (ctrl_reg[PIN_TX]) begin
      drive_next.out[PIN_TX]  = tx_active_reg & tx_shift_reg[WORD_LEN-1];
      drive_next.oe_n[PIN_TX] = ~tx_active_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_pin.out  <= '0;
      o_pin.oe_n <= '1;
    end else begin
      o_pin <= drive_next;
    end
  end

  // ==========================================================================
  // Read data
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rdata <= '0;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_CTRL:   o_rdata <= widen4(ctrl_reg);
        ADDR_DIR:    o_rdata <= widen4(dir_reg);
        ADDR_GPOUT:  o_rdata <= widen4(gpout_reg);
        ADDR_GPIN:   o_rdata <= widen4(pin_s);
        ADDR_MODE:   o_rdata <= widen4(mode_reg);
        ADDR_RXDATA: o_rdata <= DATA_W'(rx_data_reg);
        ADDR_STATUS: o_rdata <= widen4({tx_und_reg, rx_ovr_reg, rx_full_reg, ~tx_full_reg});
        default:     o_rdata <= '0;
      endcase
    end else begin
      o_rdata <= '0;
    end
  end

endmodule : ssp_pin_port

/* File: common/ssp_pkg.sv */
// Constants, register map and pin carrier types of the serial port pin block
package ssp_pkg;

  // ==========================================================================
  // Register bus
  localparam int unsigned ADDR_W    = 4;
  localparam int unsigned DATA_W    = 16;

  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_DIR    = 4'h1;
  localparam logic [3:0] ADDR_GPOUT  = 4'h2;
  localparam logic [3:0] ADDR_GPIN   = 4'h3;
  localparam logic [3:0] ADDR_MODE   = 4'h4;
  localparam logic [3:0] ADDR_TXDATA = 4'h5;
  localparam logic [3:0] ADDR_RXDATA = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;

  // ==========================================================================
  // Pin indices within the four-pin group
  localparam int unsigned NUM_PINS = 4;
  localparam int unsigned PIN_FS   = 0;
  localparam int unsigned PIN_CLK  = 1;
  localparam int unsigned PIN_RX   = 2;
  localparam int unsigned PIN_TX   = 3;

  // ==========================================================================
  // Field positions and reset values
  localparam int unsigned MODE_SYNC   = 0;
  localparam int unsigned MODE_FS_OUT = 1;
  localparam int unsigned MODE_CK_OUT = 2;
  localparam int unsigned MODE_TX_EN  = 3;

  localparam int unsigned ST_TX_EMPTY = 0;
  localparam int unsigned ST_RX_FULL  = 1;
  localparam int unsigned ST_RX_OVR   = 2;
  localparam int unsigned ST_TX_UND   = 3;

  localparam logic [3:0] CTRL_RESET  = 4'h0;
  localparam logic [3:0] DIR_RESET   = 4'h0;
  localparam logic [3:0] GPOUT_RESET = 4'h0;
  localparam logic [3:0] MODE_RESET  = 4'h0;

  // ==========================================================================
  // Serial defaults
  localparam int unsigned WORD_LEN_DEF = 16;
  localparam int unsigned CLK_DIV_DEF  = 4;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [NUM_PINS-1:0] out;
    logic [NUM_PINS-1:0] oe_n;
  } ssp_pin_drive_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ssp_bus_req_t;

endpackage : ssp_pkg

/* File: rtl/ssp_sync2.sv */
// Two-flop level synchroniser, any width
`timescale 1ns/1ps
module ssp_sync2 #(
  parameter int unsigned W = 1
) (
  // Clock
  input  wire logic         i_clk,
  // Data
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge i_clk) begin
    meta_reg <= i_d;
    o_q      <= meta_reg;
  end

endmodule : ssp_sync2

/* File: rtl/ssp_link_rx.sv */
// Receive shifter in the bit clock domain with toggle hand-off of words
`timescale 1ns/1ps
module ssp_link_rx
  import ssp_pkg::*;
#(
  parameter int unsigned WORD_LEN = WORD_LEN_DEF
) (
  // Link clock
  input  wire logic                i_link_clk,
  // Control from system domain (level)
  input  wire logic                i_enable,
  // Pins
  input  wire logic                i_frame_sync,
  input  wire logic                i_rx_data,
  // Word hand-off
  output logic      [WORD_LEN-1:0] o_word,
  output logic                     o_toggle
);

  localparam int unsigned CNT_W = $clog2(WORD_LEN + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(WORD_LEN - 1);

  logic [2:0]          in_s;
  logic                en_s;
  logic                fs_s;
  logic                rd_s;
  logic [WORD_LEN-1:0] shift_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic                busy_reg;

  ssp_sync2 #(.W(3)) u_sync (
    .i_clk (i_link_clk),
    .i_d   ({i_enable, i_frame_sync, i_rx_data}),
    .o_q   (in_s)
  );

  assign en_s = in_s[2];
  assign fs_s = in_s[1];
  assign rd_s = in_s[0];

  // Shift in receive pin bits
  always_ff @(posedge i_link_clk) begin
    if (!en_s) begin
      busy_reg <= 1'b0;
      cnt_reg  <= '0;
      o_toggle <= 1'b0;
    end else if (fs_s && !busy_reg) begin
      shift_reg <= {shift_reg[WORD_LEN-2:0], rd_s};
      cnt_reg   <= CNT_W'(1);
      busy_reg  <= 1'b1;
    end else if (busy_reg) begin
      shift_reg <= {shift_reg[WORD_LEN-2:0], rd_s};
      cnt_reg   <= cnt_reg + CNT_W'(1);
      if (cnt_reg == LAST) begin
        busy_reg <= 1'b0;
        o_word   <= {shift_reg[WORD_LEN-2:0], rd_s};
        o_toggle <= ~o_toggle;
      end
    end
  end

endmodule : ssp_link_rx

/* File: dv/ssp_pin_port_monitor.sv */
// Concurrent checks on the pins of the serial port pin block
`timescale 1ns/1ps
module ssp_pin_port_monitor
  import ssp_pkg::*;
#(
  parameter int unsigned WORD_LEN = WORD_LEN_DEF,
  parameter int unsigned CLK_DIV  = CLK_DIV_DEF
) (
  // Clocks and reset
  input wire logic                    i_clk,
  input wire logic                    i_reset,
  input wire logic                    i_link_clk,
  // Register port
  input wire ssp_pkg::ssp_bus_req_t   i_bus,
  input wire logic [DATA_W-1:0]       o_rdata,
  // Pins
  input wire logic [NUM_PINS-1:0]     i_pin,
  input wire ssp_pkg::ssp_pin_drive_t o_pin
);
  import ssp_pkg::*;
  // ====
  // Shadow registers
  logic [3:0] ctrl_reg, dir_reg, gpout_reg, mode_reg;
  logic [1:0] quiet_reg;
  logic [9:0] run_reg;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_reg  <= 4'h0;
      dir_reg   <= 4'h0;
      gpout_reg <= 4'h0;
      mode_reg  <= 4'h0;
    end else if (i_bus.wr) begin
      if (i_bus.addr == ADDR_CTRL) ctrl_reg <= i_bus.wdata[3:0];
      if (i_bus.addr == ADDR_DIR) dir_reg <= i_bus.wdata[3:0];
      if (i_bus.addr == ADDR_GPOUT) gpout_reg <= i_bus.wdata[3:0];
      if (i_bus.addr == ADDR_MODE) mode_reg <= i_bus.wdata[3:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || i_bus.wr) begin
      quiet_reg <= 2'd0;
    end else if (quiet_reg != 2'd3) begin
      quiet_reg <= quiet_reg + 2'd1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || o_pin.oe_n[PIN_TX] || !ctrl_reg[PIN_TX]) begin
      run_reg <= 10'h000;
    end else begin
      run_reg <= run_reg + 10'h001;
    end
  end

  // ====
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_reset_inputs: assert property (
    $fell(i_reset) |-> o_pin.oe_n == 4'hF && o_pin.out == 4'h0)
    else $error("pins not inputs after reset");
  chk_gp_dir: assert property (
    quiet_reg == 2'd3 |-> ((o_pin.oe_n ^ ~dir_reg) & ~ctrl_reg) == 4'h0)
    else $error("port pin direction differs from direction bit");
  chk_gp_out: assert property (
    quiet_reg == 2'd3 |-> ((o_pin.out ^ gpout_reg) & dir_reg & ~ctrl_reg) == 4'h0)
    else $error("port pin output differs from output bit");
  chk_fs_input: assert property (
    ctrl_reg[PIN_FS] && !mode_reg[MODE_FS_OUT] && quiet_reg == 2'd3 |-> o_pin.oe_n[PIN_FS])
    else $error("frame sync driven while set as input");
  chk_clk_input: assert property (
    ctrl_reg[PIN_CLK] && !mode_reg[MODE_CK_OUT] && quiet_reg == 2'd3 |-> o_pin.oe_n[PIN_CLK])
    else $error("bit clock driven while set as input");
  chk_rx_input: assert property (
    ctrl_reg[PIN_RX] && quiet_reg == 2'd3 |-> o_pin.oe_n[PIN_RX])
    else $error("receive pin driven");
  chk_tx_burst: assert property (
    run_reg <= WORD_LEN * 2 * CLK_DIV)
    else $error("transmit pin driven beyond one word");
  chk_clk_period: assert property (
    quiet_reg == 2'd3 && ctrl_reg[PIN_CLK] && mode_reg[MODE_CK_OUT]
    && $changed(o_pin.out[PIN_CLK])
    |=> ($stable(o_pin.out[PIN_CLK]) || quiet_reg != 2'd3)[*3])
    else $error("generated bit clock half period too short");
endmodule : ssp_pin_port_monitor

bind ssp_pin_port ssp_pin_port_monitor #(.WORD_LEN(WORD_LEN), .CLK_DIV(CLK_DIV))
  ssp_pin_port_monitor_inst (.i_clk(i_clk), .i_reset(i_reset), .i_link_clk(i_link_clk),
  .i_bus(i_bus), .o_rdata(o_rdata), .i_pin(i_pin), .o_pin(o_pin));

/* File: dv/ssp_codec_model.sv */
// Behavioural external codec driving bit clock, frame sync and receive data
`timescale 1ns/1ps
module ssp_codec_model
  import ssp_pkg::*;
#(
  parameter int unsigned WORD_LEN = WORD_LEN_DEF,
  parameter real         HALF_NS  = 15.0
) (
  // Control
  input  wire logic                i_go,
  input  wire logic [WORD_LEN-1:0] i_word,
  // Pins
  output logic                     o_clk,
  output logic                     o_fs,
  output logic                     o_rx
);
  initial begin
    o_clk = 1'b0;
    o_fs  = 1'b0;
    o_rx  = 1'b0;
  end

  // ====
  // One frame, MSB first, two trailing clocks, clock idle low
  always @(posedge i_go) begin
    for (int i = WORD_LEN - 1; i >= -2; i--) begin
      o_fs = (i == WORD_LEN - 1);
      o_rx = (i >= 0) ? i_word[i] : ~o_rx;
      #(HALF_NS) o_clk = 1'b1;
      #(HALF_NS) o_clk = 1'b0;
    end
    o_fs = 1'b0;
    o_rx = ~o_rx;
  end
endmodule : ssp_codec_model

/* File: dv/ssp_pin_port_tb.sv */
// Self-checking testbench of the serial port pin block
`timescale 1ns/1ps
module ssp_pin_port_tb;
  import ssp_pkg::*;
  logic              i_clk, i_reset, go, tx_on, rd_d;
  ssp_bus_req_t      bus;
  logic [DATA_W-1:0] rdata;
  ssp_pin_drive_t    pins;
  logic [3:0]        pin_w, ext;
  logic              fs_w, clk_w, rx_w;
  logic [15:0]       word, tx_sh;
  logic [15:0]       rd_q[$], tx_q[$];
  int                miscompares, comparisons, cyc, nbits, seed;

  assign ext   = {~pins.out[PIN_TX], rx_w, clk_w, fs_w};
  assign pin_w = (pins.out & ~pins.oe_n) | (ext & pins.oe_n);

  ssp_pin_port ssp_pin_port_inst (
    .i_clk      (i_clk),
    .i_reset    (i_reset),
    .i_link_clk (pin_w[PIN_CLK]),
    .i_bus      (bus),
    .o_rdata    (rdata),
    .i_pin      (pin_w),
    .o_pin      (pins)
  );

  ssp_codec_model ssp_codec_model_inst (
    .i_go   (go),
    .i_word (word),
    .o_clk  (clk_w),
    .o_fs   (fs_w),
    .o_rx   (rx_w)
  );

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ====
  // Checking and bus tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("miscompares %0d comparisons %0d", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus.addr  <= a;
    bus.wdata <= d;
    bus.wr    <= 1'b1;
    @(posedge i_clk);
    bus.wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge i_clk);
    bus.rd   <= 1'b0;
  endtask : rd

  // ====
  // Result watchers
  always @(posedge i_clk) begin
    rd_d <= bus.rd;
    if (rd_d) check(rdata, rd_q.pop_front());
  end

  always @(negedge pin_w[PIN_CLK]) begin
    if (tx_on && !pins.oe_n[PIN_TX]) begin
      tx_sh = {tx_sh[14:0], pin_w[PIN_TX]};
      nbits++;
      if (nbits == WORD_LEN_DEF) begin
        check(tx_sh, tx_q.pop_front());
        nbits = 0;
      end
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  // ====
  // Scenarios
  initial begin
    seed    = 32'hd657;
    bus     = '0;
    go      = 1'b0;
    tx_on   = 1'b0;
    word    = 16'h0000;
    i_reset = 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    #1;
    check({12'h000, pins.oe_n}, 16'h000F);
    rd(ADDR_CTRL, 16'h0000);
    rd(ADDR_DIR, 16'h0000);
    rd(4'hC, 16'h0000);
    repeat (4) begin
      word = $random(seed);
      wr(ADDR_DIR, {12'h000, word[3:0]});
      wr(ADDR_GPOUT, {12'h000, word[7:4]});
      repeat (4) @(posedge i_clk);
      #1;
      check({12'h000, pins.oe_n}, {12'h000, ~word[3:0]});
      check({12'h000, pins.out & word[3:0]}, {12'h000, word[7:4] & word[3:0]});
    end
    wr(ADDR_DIR, 16'h0000);
    // Idle frame settles the link receiver while it is still disabled
    @(posedge i_clk);
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
    repeat (150) @(posedge i_clk);
    wr(ADDR_CTRL, 16'h000F);
    wr(ADDR_MODE, 16'h0001);
    repeat (2) begin
      word = $random(seed);
      @(posedge i_clk);
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      repeat (150) @(posedge i_clk);
    end
    rd(ADDR_STATUS, 16'h0007);
    rd(ADDR_RXDATA, word);
    #1;
    check({15'h0000, pins.oe_n[PIN_TX]}, 16'h0001);
    tx_on = 1'b1;
    nbits = 0;
    word  = $random(seed);
    tx_q.push_back(word);
    wr(ADDR_TXDATA, word);
    wr(ADDR_MODE, 16'h000F);
    for (int n = 0; n < 600 && tx_q.size() != 0; n++) @(posedge i_clk);
    repeat (12) @(posedge i_clk);
    #1;
    check({15'h0000, pins.oe_n[PIN_TX]}, 16'h0001);
    check(16'(tx_q.size()), 16'h0000);
    stop_test();
  end
endmodule : ssp_pin_port_tb
